// >>> logic/mspi_bank.sv
// memory size view registers and program page index register
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "mspi_params.svh"
module mspi_bank #(
  parameter bit LOCKED_PAGE = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_special_mode,
  input wire logic i_register_space_switch,
  input wire logic [1:0] i_eeprom_space_switches,
  input wire logic [2:0] i_ram_space_switches,
  input wire logic [1:0] i_program_memory_space_switches,
  input wire logic [1:0] i_paging_partition_switches,
  input wire logic i_ram_alignment_bit,
  input wire logic i_call_wr,
  input wire logic [5:0] i_call_wdata,
  output logic [5:0] o_call_rdata,
  input wire logic [15:0] i_cpu_addr,
  output logic o_page_window_hit,
  output logic o_page_internal,
  output logic [19:0] o_paged_addr,
  output logic [15:0] o_ram_base,
  output logic [15:0] o_ram_region_bytes
);
  localparam logic [5:0] PAGE_RST = LOCKED_PAGE ? `MSPI_PAGE_RST_LOCKED : `MSPI_PAGE_RST_OPEN;
  mspi_pkg::mspi_state_t st_ff;
  mspi_pkg::mspi_state_t nxt_st;
  mspi_pkg::mspi_ram_map_t ram_map;
  logic [7:0] cfg_a;
  logic [7:0] cfg_b;
  logic page_wr_ok;
  logic [5:0] first_int;

  function automatic logic [5:0] int_first(input logic [1:0] code);
    unique case (code)
      2'h0: int_first = `MSPI_INT_FIRST_00;
      2'h1: int_first = `MSPI_INT_FIRST_01;
      2'h2: int_first = `MSPI_INT_FIRST_10;
      2'h3: int_first = `MSPI_INT_FIRST_11;
    endcase
  endfunction : int_first

  ////////////////////////////////////////////////////////////////////////
  // live switch views; zeros fill the unused positions
  always_comb
  begin
    cfg_a = 8'h00;
    cfg_a[`MSPI_A_REG_BIT] = i_register_space_switch; // [RULE_01] [RULE_03]
    cfg_a[`MSPI_A_EEP_LSB +: 2] = i_eeprom_space_switches; // [RULE_04]
    cfg_a[`MSPI_A_RAM_LSB +: 3] = i_ram_space_switches; // [RULE_05] [RULE_18]
    cfg_b = 8'h00;
    cfg_b[`MSPI_B_ROM_LSB +: 2] = i_program_memory_space_switches; // [RULE_08] [RULE_09]
    cfg_b[`MSPI_B_PAG_LSB +: 2] = i_paging_partition_switches; // [RULE_10] [RULE_18]
  end

  mspi_ram_map u_ram_map (
    .i_ram_code(i_ram_space_switches),
    .i_ram_align_high(i_ram_alignment_bit),
    .o_map(ram_map)
  );
  assign o_ram_base = ram_map.ram_base;
  assign o_ram_region_bytes = ram_map.ram_region_bytes;

  ////////////////////////////////////////////////////////////////////////
  // locked build lets the bus write the index only in special modes
  assign page_wr_ok = !LOCKED_PAGE || i_special_mode; // [RULE_16]

  // state update; call path beats a bus write in the same cycle
  always_comb
  begin
    nxt_st = st_ff;
    if (i_call_wr)
      nxt_st.page_ff = i_call_wdata; // [RULE_14] [RULE_15]
    else if (i_wr && i_addr == `MSPI_OFF_PAGE && page_wr_ok)
      nxt_st.page_ff = i_wdata[5:0]; // [RULE_13] [RULE_18]
    // size register writes fall through and change nothing
    nxt_st.rdata_ff = 8'h00; // [RULE_02]
    if (i_rd)
    begin
      unique case (i_addr)
        `MSPI_OFF_CFG_A: nxt_st.rdata_ff = cfg_a; // [RULE_19]
        `MSPI_OFF_CFG_B: nxt_st.rdata_ff = cfg_b;
        `MSPI_OFF_PAGE: nxt_st.rdata_ff = {2'h0, st_ff.page_ff};
        default: nxt_st.rdata_ff = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_ff.page_ff <= PAGE_RST; // [RULE_16]
      st_ff.rdata_ff <= 8'h00;
    end
    else
      st_ff <= nxt_st;
  end

  ////////////////////////////////////////////////////////////////////////
  // window decode uses the registered index only
  assign o_rdata = st_ff.rdata_ff;
  assign o_call_rdata = st_ff.page_ff; // [RULE_14]
  assign first_int = int_first(i_paging_partition_switches);
  assign o_page_window_hit = i_cpu_addr >= `MSPI_WIN_LO && i_cpu_addr <= `MSPI_WIN_HI; // [RULE_11]
  assign o_page_internal = o_page_window_hit && st_ff.page_ff >= first_int; // [RULE_17]
  assign o_paged_addr = {st_ff.page_ff, i_cpu_addr[13:0]}; // [RULE_12]

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_cfg_a_read: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_01]
    i_rd && i_addr == `MSPI_OFF_CFG_A |=> o_rdata == $past(cfg_a))
    else $error("config a read wrong");
  chk_cfg_b_read: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_08]
    i_rd && i_addr == `MSPI_OFF_CFG_B |=> o_rdata[5:2] == 4'h0 && o_rdata == $past(cfg_b))
    else $error("config b read wrong");
  chk_size_write_inert: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_02]
    i_wr && i_addr != `MSPI_OFF_PAGE && !i_call_wr |=> $stable(st_ff.page_ff))
    else $error("size write changed state");
  chk_page_bus_write: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_13]
    i_wr && i_addr == `MSPI_OFF_PAGE && page_wr_ok && !i_call_wr
    |=> o_paged_addr[19:14] == $past(i_wdata[5:0]))
    else $error("page write not seen next cycle");
  chk_page_call_write: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_15]
    i_call_wr |=> o_call_rdata == $past(i_call_wdata))
    else $error("call path write lost");
  chk_page_locked: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_16]
    i_wr && !page_wr_ok && !i_call_wr |=> $stable(st_ff.page_ff))
    else $error("locked page written");
  chk_page_readback: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_19]
    i_rd && i_addr == `MSPI_OFF_PAGE |=> o_rdata == {2'h0, $past(st_ff.page_ff)})
    else $error("page readback wrong");
  chk_internal_split: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_17]
    o_page_window_hit && i_paging_partition_switches == 2'h0
    |-> o_page_internal == (st_ff.page_ff[5:3] == 3'h7))
    else $error("partition decode wrong");
  chk_window_range: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_11]
    o_page_window_hit |-> i_cpu_addr[15:14] == 2'h2)
    else $error("window range wrong");

  ////////////////////////////////////////////////////////////////////////
  // reset and read port checks

  // reset is checked without the disable so the loaded value is seen
  chk_reset_values: assert property (@(posedge i_clk) // [RULE_16]
    i_rst |=> o_call_rdata == PAGE_RST && o_rdata == 8'h00)
    else $error("reset values wrong");

  // read data only stands after a read strobe
  chk_idle_rdata: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_19]
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data without strobe");

  // offsets outside the bank answer with zero
  chk_unmapped_read: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_19]
    i_rd && i_addr != `MSPI_OFF_CFG_A && i_addr != `MSPI_OFF_CFG_B
    && i_addr != `MSPI_OFF_PAGE |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");

  // a write strobe alone never produces read data
  chk_size_write_rdata: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_02]
    i_wr && !i_rd |=> o_rdata == 8'h00)
    else $error("write produced read data");

  ////////////////////////////////////////////////////////////////////////
  // field placement in the size views

  // register space bit sits at the top of config a
  chk_cfg_a_reg_bit: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_03]
    i_rd && i_addr == `MSPI_OFF_CFG_A |=> o_rdata[7] == $past(i_register_space_switch))
    else $error("register space bit wrong");

  // eeprom code in bits 5:4
  chk_cfg_a_eeprom: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_04]
    i_rd && i_addr == `MSPI_OFF_CFG_A |=> o_rdata[5:4] == $past(i_eeprom_space_switches))
    else $error("eeprom field wrong");

  // ram code in bits 2:0
  chk_cfg_a_ram: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_05]
    i_rd && i_addr == `MSPI_OFF_CFG_A |=> o_rdata[2:0] == $past(i_ram_space_switches))
    else $error("ram field wrong");

  // gaps in config a read as zero
  chk_cfg_a_gaps: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_18]
    i_rd && i_addr == `MSPI_OFF_CFG_A |=> o_rdata[6] == 1'b0 && o_rdata[3] == 1'b0)
    else $error("config a gap not zero");

  // program memory code in bits 7:6
  chk_cfg_b_rom: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_09]
    i_rd && i_addr == `MSPI_OFF_CFG_B
    |=> o_rdata[7:6] == $past(i_program_memory_space_switches))
    else $error("program memory field wrong");

  // paging partition code in bits 1:0
  chk_cfg_b_paging: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_10]
    i_rd && i_addr == `MSPI_OFF_CFG_B
    |=> o_rdata[1:0] == $past(i_paging_partition_switches))
    else $error("paging field wrong");

  // upper two index bits are not stored and read as zero
  chk_page_upper_zero: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_18]
    i_rd && i_addr == `MSPI_OFF_PAGE |=> o_rdata[7:6] == 2'h0)
    else $error("page upper bits not zero");

  ////////////////////////////////////////////////////////////////////////
  // page index update paths

  // the call path wins a same-cycle clash with a bus write
  chk_call_beats_bus: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_14]
    i_call_wr && i_wr && i_addr == `MSPI_OFF_PAGE |=> o_call_rdata == $past(i_call_wdata))
    else $error("bus write beat call path");

  // without a write the index holds
  chk_page_hold: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_12]
    !i_call_wr && !(i_wr && i_addr == `MSPI_OFF_PAGE) |=> $stable(st_ff.page_ff))
    else $error("page changed without write");

  // index must not move in the cycle of the bus write itself
  chk_page_no_early: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_13]
    i_wr && i_addr == `MSPI_OFF_PAGE && !i_call_wr |-> o_paged_addr[19:14] == st_ff.page_ff)
    else $error("page write seen too early");

  ////////////////////////////////////////////////////////////////////////
  // window decode

  // offset inside the window passes straight through
  chk_paged_addr_low: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_11]
    o_paged_addr[13:0] == i_cpu_addr[13:0])
    else $error("window offset wrong");

  // every address of the window must hit
  chk_window_inside: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_11]
    i_cpu_addr[15:14] == 2'h2 |-> o_page_window_hit)
    else $error("window miss inside range");

  // internal only ever qualifies a window access
  chk_internal_needs_hit: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_17]
    !o_page_window_hit |-> !o_page_internal)
    else $error("internal outside window");

  // quarter split: top sixteen pages on chip
  chk_internal_split_01: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_17]
    o_page_window_hit && i_paging_partition_switches == 2'h1
    |-> o_page_internal == (st_ff.page_ff[5:4] == 2'h3))
    else $error("partition 01 decode wrong");

  // half split: upper half of the pages on chip
  chk_internal_split_10: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_17]
    o_page_window_hit && i_paging_partition_switches == 2'h2
    |-> o_page_internal == st_ff.page_ff[5])
    else $error("partition 10 decode wrong");

  // all on chip: every window access internal
  chk_internal_full: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_17]
    o_page_window_hit && i_paging_partition_switches == 2'h3 |-> o_page_internal)
    else $error("partition 11 decode wrong");

  // each page bit lands on its own upper address line
  for (genvar g = 0; g < 6; g++)
  begin : gen_page_bits
    chk_page_bit: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_12]
      o_paged_addr[14 + g] == st_ff.page_ff[g])
      else $error("page bit misplaced");
  end

  ////////////////////////////////////////////////////////////////////////
  // ram placement

  // full-size top code always starts at zero
  chk_ram_base_full: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_06]
    i_ram_space_switches == 3'h7 |-> o_ram_base == 16'h0000)
    else $error("full ram base wrong");

  // smallest code keeps its fixed base
  chk_ram_base_small: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_06]
    i_ram_space_switches == 3'h0 |-> o_ram_base == 16'h0800)
    else $error("small ram base wrong");

  // low alignment pins larger codes to the region bottom
  chk_ram_align_low: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_07]
    !i_ram_alignment_bit && i_ram_space_switches != 3'h0 |-> o_ram_base == 16'h0000)
    else $error("low aligned ram base wrong");

  // region grows to the top size for the upper codes
  chk_ram_region_top: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_05]
    i_ram_space_switches[2] |-> o_ram_region_bytes == 16'h4000)
    else $error("ram region wrong");

  ////////////////////////////////////////////////////////////////////////
  // scenario covers
  cov_external_window: cover property (@(posedge i_clk) disable iff (i_rst)
    o_page_window_hit && !o_page_internal);
  cov_locked_refuse: cover property (@(posedge i_clk) disable iff (i_rst)
    i_wr && i_addr == `MSPI_OFF_PAGE && !page_wr_ok);
  cov_page_write: cover property (@(posedge i_clk) disable iff (i_rst)
    i_wr && i_addr == `MSPI_OFF_PAGE ##1 o_page_internal);
  cov_call_write: cover property (@(posedge i_clk) disable iff (i_rst) i_call_wr);
  cov_cfg_read: cover property (@(posedge i_clk) disable iff (i_rst)
    i_rd && i_addr == `MSPI_OFF_CFG_A ##1 i_rd && i_addr == `MSPI_OFF_CFG_B);
endmodule : mspi_bank

// >>> logic/mspi_params.svh
// constants for the memory size and page index register bank
// Notes on behaviour
// RULE_01: config A reads back register, eeprom and ram space switch levels.
// RULE_02: size registers readable anytime; writes to them change nothing.
// RULE_03: config A bit 7 is 0 for 1K register space, 1 for 2K.
// RULE_04: config A bits 5:4 give eeprom space 0K, 2K, 4K, 8K.
// RULE_05: three ram switch bits give ram size 2K to 16K in 2K steps.
// RULE_06: ram reset base address follows from the ram switch code.
// RULE_07: smaller ram sits inside its mappable region per the alignment bit.
// RULE_08: config B reads back program memory and paging partition switches.
// RULE_09: config B bits 7:6 give program memory 0K, 16K, 48K, 64K.
// RULE_10: config B bits 1:0 give the off-chip/on-chip paged split.
// RULE_11: six-bit page index picks the 16K page shown at 0x8000-0xbfff.
// RULE_12: page index is a plain binary page number, 0 to 63.
// RULE_13: a bus write to the page index reaches the window one cycle later.
// RULE_14: far call and return reach the page index over a dedicated path.
// RULE_15: a special path update completes before its instruction ends.
// RULE_16: page index resets to 0x00 (writes any mode) or 0x3c (special only).
// RULE_17: page window access is internal or external by index and partition.
// RULE_18: unimplemented bits read zero and ignore writes.
// RULE_19: all three registers readable anytime with no read side effect.
`ifndef MSPI_PARAMS_SVH
`define MSPI_PARAMS_SVH
`define MSPI_OFF_CFG_A 8'h1c
`define MSPI_OFF_CFG_B 8'h1d
`define MSPI_OFF_PAGE 8'h30
`define MSPI_A_REG_BIT 7
`define MSPI_A_EEP_LSB 4
`define MSPI_A_RAM_LSB 0
`define MSPI_B_ROM_LSB 6
`define MSPI_B_PAG_LSB 0
`define MSPI_PAGE_RST_OPEN 6'h00
`define MSPI_PAGE_RST_LOCKED 6'h3c
`define MSPI_RAM_POS_RESET 8'h09
`define MSPI_WIN_LO 16'h8000
`define MSPI_WIN_HI 16'hbfff
`define MSPI_INT_FIRST_00 6'h38
`define MSPI_INT_FIRST_01 6'h30
`define MSPI_INT_FIRST_10 6'h20
`define MSPI_INT_FIRST_11 6'h00
`endif

// >>> logic/mspi_pkg.sv
// types shared by the memory size and page index bank
package mspi_pkg;
  typedef struct packed {
    logic [5:0] page_ff;
    logic [7:0] rdata_ff;
  } mspi_state_t;
  typedef struct packed {
    logic [15:0] ram_base;
    logic [15:0] ram_region_bytes;
  } mspi_ram_map_t;
endpackage : mspi_pkg

// >>> logic/mspi_ram_map.sv
// ram placement decode from the ram space switches
`timescale 1ns/1ps
`include "mspi_params.svh"
module mspi_ram_map (
  input wire logic [2:0] i_ram_code,
  input wire logic i_ram_align_high,
  output mspi_pkg::mspi_ram_map_t o_map
);
  logic [15:0] alloc;
  logic [15:0] region;
  // allocation is 2K per step; region rounds up to a power of two
  always_comb
  begin
    alloc = {1'b0, ({1'b0, i_ram_code} + 4'h1), 11'h000}; // [RULE_05]
    unique case (i_ram_code)
      3'h0: region = 16'h0800;
      3'h1: region = 16'h1000;
      3'h2, 3'h3: region = 16'h2000;
      default: region = 16'h4000;
    endcase
    o_map.ram_region_bytes = region;
    // reset base sits so ram ends at the region top, code 0 fixed at 0x0800; low align moves the others to 0
    if (i_ram_align_high || alloc == region) // [RULE_07]
      o_map.ram_base = (i_ram_code == 3'h0) ? 16'h0800 : region - alloc; // [RULE_06]
    else
      o_map.ram_base = 16'h0000;
  end
endmodule : mspi_ram_map

// >>> bench/mspi_cpu_model.sv
// bus master model standing in for the cpu core on the register port
`timescale 1ns/1ps
module mspi_cpu_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial
  begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // one-cycle write; released lines flip so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask : wr
  // read data only stands in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    @(negedge i_clk);
    d = i_rdata;
  endtask : rd
endmodule : mspi_cpu_model

// >>> bench/memory_size_and_page_index_tb.sv
// self-checking bench for the memory size and page index bank
`timescale 1ns/1ps
module memory_size_and_page_index_tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic spec = 1'b0, rsw = 1'b0, aln = 1'b1, cwr = 1'b0, wr, rd, hit, intl;
  logic [1:0] eep = 2'h0, rom = 2'h0, pag = 2'h0;
  logic [2:0] ram = 3'h0;
  logic [5:0] cwd = 6'h00, crd, lk_crd;
  logic [15:0] caddr = 16'hbfff, rbase, rsize;
  logic [7:0] addr, wdata, rdata, d;
  logic [19:0] paddr;
  logic [42:0] r;
  int miscompares = 0;
  int checks_done = 0;
  // rows: reg, eeprom, ram, rom, paging straps, alignment; cfg a, cfg b, ram base
  logic [42:0] rows [4] = '{
    {1'b1, 2'h3, 3'h5, 2'h2, 2'h1, 1'b1, 8'hb5, 8'h81, 16'h1000},
    {1'b0, 2'h0, 3'h0, 2'h0, 2'h0, 1'b0, 8'h00, 8'h00, 16'h0800},
    {1'b0, 2'h2, 3'h4, 2'h3, 2'h3, 1'b1, 8'h24, 8'hc3, 16'h1800},
    {1'b1, 2'h1, 3'h7, 2'h1, 2'h2, 1'b0, 8'h97, 8'h42, 16'h0000}};
  always #5 i_clk = ~i_clk;
  mspi_cpu_model cpu_u (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd));
  mspi_bank #(.LOCKED_PAGE(1'b0)) dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_special_mode(spec),
    .i_register_space_switch(rsw), .i_eeprom_space_switches(eep),
    .i_ram_space_switches(ram), .i_program_memory_space_switches(rom),
    .i_paging_partition_switches(pag), .i_ram_alignment_bit(aln), .i_call_wr(cwr),
    .i_call_wdata(cwd), .o_call_rdata(crd), .i_cpu_addr(caddr), .o_page_window_hit(hit),
    .o_page_internal(intl), .o_paged_addr(paddr), .o_ram_base(rbase),
    .o_ram_region_bytes(rsize));
  // locked build shares the bus; only its index is watched
  mspi_bank #(.LOCKED_PAGE(1'b1)) dut_lk_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(), .i_special_mode(spec),
    .i_register_space_switch(rsw), .i_eeprom_space_switches(eep),
    .i_ram_space_switches(ram), .i_program_memory_space_switches(rom),
    .i_paging_partition_switches(pag), .i_ram_alignment_bit(aln), .i_call_wr(cwr),
    .i_call_wdata(cwd), .o_call_rdata(lk_crd), .i_cpu_addr(caddr), .o_page_window_hit(),
    .o_page_internal(), .o_paged_addr(), .o_ram_base(), .o_ram_region_bytes());
  //////////////////////////////////////////////////////////////////////////////
  // one compare, counted; unknowns never pass
  task automatic chk(input string n, input logic [19:0] s, input logic [19:0] e);
    checks_done++;
    if (s !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // watchdog well beyond the fewer than a hundred cycles the tests need
  initial
  begin
    #50000;
    miscompares++;
    conclude();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    chk("rdata_idle", {12'h0, rdata}, 20'h0);
    cpu_u.rd(8'h30, d);
    chk("page_reset", {12'h0, d}, 20'h0);
    $display("test reset done");
    // strap rows; writes to the size views must bounce off
    foreach (rows[i])
    begin
      r = rows[i];
      @(posedge i_clk);
      {rsw, eep, ram, rom, pag, aln} <= r[42:32];
      cpu_u.wr(8'h1c, ~r[31:24]);
      cpu_u.wr(8'h1d, ~r[23:16]);
      cpu_u.rd(8'h1c, d);
      chk("cfg_a", {12'h0, d}, {12'h0, r[31:24]});
      cpu_u.rd(8'h1d, d);
      chk("cfg_b", {12'h0, d}, {12'h0, r[23:16]});
      chk("ram_base", {4'h0, rbase}, {4'h0, r[15:0]});
    end
    $display("test straps done");
    // upper bits dropped; top page is internal with the smallest on-chip part
    cpu_u.wr(8'h30, 8'hff);
    cpu_u.rd(8'h30, d);
    chk("page_read", {12'h0, d}, 20'h0003f);
    @(posedge i_clk);
    pag <= 2'h0;
    @(negedge i_clk);
    chk("paged_addr", paddr, 20'hfffff);
    chk("internal_hi", {19'h0, intl}, 20'h1);
    // new index must not show in the cycle of the write itself
    fork
      cpu_u.wr(8'h30, 8'h37);
      begin
        @(posedge i_clk);
        #1 chk("page_early", {14'h0, paddr[19:14]}, 20'h3f);
      end
    join
    #1 chk("page_late", {14'h0, paddr[19:14]}, 20'h37);
    chk("internal_lo", {19'h0, intl}, 20'h0);
    caddr <= 16'hc000;
    #1 chk("window_out", {19'h0, hit}, 20'h0);
    cpu_u.rd(8'h1e, d);
    chk("unmapped", {12'h0, d}, 20'h0);
    $display("test page done");
    // locked build: bus writes so far were refused outside special mode
    chk("lk_reset", {14'h0, lk_crd}, 20'h3c);
    cpu_u.wr(8'h30, 8'h05);
    #1 chk("lk_refused", {14'h0, lk_crd}, 20'h3c);
    spec <= 1'b1;
    cpu_u.wr(8'h30, 8'h0a);
    #1 chk("lk_special", {14'h0, lk_crd}, 20'h0a);
    spec <= 1'b0;
    $display("test locked done");
    // call path write completes by the next edge
    @(posedge i_clk);
    cwr <= 1'b1;
    cwd <= 6'h15;
    @(posedge i_clk);
    cwr <= 1'b0;
    #1 chk("call_page", {14'h0, crd}, 20'h15);
    $display("test call done");
    conclude();
  end
endmodule : memory_size_and_page_index_tb
